// ==== rtl/gpio_expander_pin_interrupt_core.sv ====
// register file, pin control and edge interrupts of the expander
// interrupt modes per input pin, from the rise and fall selects:
//   neither set: any edge away from the captured level sets the
//     flag; a state read or a return to that level clears it
//   rise only:   a rising edge sets, only a state read clears
//   fall only:   a falling edge sets, only a state read clears
//   both set:    either edge sets, only a state read clears
// an output pin or one with its enable clear never flags, and any
// flag it held is dropped at once
//
// timing with the filter off: a pin change passes the two-flop
// synchroniser, shows as an edge in that same cycle, and the flag and
// the interrupt output follow on the next edge; with the filter on
// the new level must first hold for the full filter count, so
// shorter pulses never reach edge detection
//
// register port: one-cycle read and write strobes with an address
// equal to the command byte value; read data stands for one cycle,
// one cycle after its strobe, and is zero otherwise; a read and a
// write in one cycle are both honoured, the read seeing old data
//
// hazards: an edge in the cycle of a state read still sets its
// flag, but in any-edge mode the read captures the new level and
// revert clearing drops that flag one cycle later; toggling a filter
// enable can itself make an edge when filtered and raw levels differ
//
// limitation: edge detection uses the true pin level, so the
// polarity inversion changes only what a state read shows
//
// reset: all pins come up as inputs with their filters on, every
// interrupt enable clear, and the interrupt output released
`timescale 1ns/1ps
module gpio_expander_pin_interrupt_core
	import gpio_pkg::*;
(
	input  wire logic                  clk_i,       // system clock
	input  wire logic                  srst_i,      // sync reset
	input  wire logic                  reg_wr_i,    // register write
	input  wire logic                  reg_rd_i,    // register read
	input  wire logic [ADDR_WIDTH-1:0] reg_addr_i,  // register address
	input  wire logic [BANK_WIDTH-1:0] reg_wdata_i, // write data
	output logic      [BANK_WIDTH-1:0] reg_rdata_o, // read data
	output logic                       reg_rvalid_o,// read data valid
	input  wire logic [PIN_COUNT-1:0]  gpio_in_i,   // pin input levels
	output logic      [PIN_COUNT-1:0]  gpio_out_o,  // pin output levels
	output logic      [PIN_COUNT-1:0]  gpio_oe_o,   // pin drive enables
	output logic                       irq_n_o      // interrupt, low
);
	// complete state of the core
	typedef struct packed {
		logic [15:0] out_level; // output level register
		logic [15:0] invert;    // input polarity inversion
		logic [15:0] dir;       // direction, one is input
		logic [15:0] irq_en;    // interrupt enables
		logic [15:0] tri_en;    // output three-state controls
		logic [15:0] rise_sel;  // rising-edge selects
		logic [15:0] fall_sel;  // falling-edge selects
		logic [15:0] filt_en;   // glitch filter enables
		logic [15:0] status;    // pending interrupt flags
		logic [15:0] captured;  // levels seen at last state read
		logic [15:0] level_d;   // qualified level, one cycle old
		logic [15:0] oe;        // registered drive enables
		logic        irq_n;     // registered interrupt pin
		logic [7:0]  rdata;     // registered read data
		logic        rvalid;    // read data valid strobe
	} core_state_t;

	// values taken on reset
	localparam core_state_t CORE_RESET = '{
		out_level: OUT_LEVEL_RESET,
		invert:    INVERT_RESET,
		dir:       DIR_RESET,
		irq_en:    IRQ_EN_RESET,
		tri_en:    TRI_RESET,
		rise_sel:  RISE_RESET,
		fall_sel:  FALL_RESET,
		filt_en:   FILT_EN_RESET,
		oe:        ~DIR_RESET & ~TRI_RESET,
		irq_n:     1'b1,
		default:   '0
	};

	core_state_t st;      // registered state
	core_state_t next_st; // next state

	// working terms, all filled by the combinational process
	logic [15:0] level;      // level that feeds edge detection
	logic [15:0] rise;       // qualified rising edges
	logic [15:0] fall;       // qualified falling edges
	logic [15:0] armed;      // inputs with interrupts enabled
	logic [15:0] any_mode;   // pins in any-edge, revert-clear mode
	logic [15:0] set_irq;    // new interrupt events this cycle
	logic [15:0] read_clr;   // bits cleared by a state read
	logic [15:0] revert_clr; // bits cleared by input reverting
	logic [15:0] state_view; // what a state read shows
	logic [15:0] bank_mask;  // pins of the addressed bank
	reg_id_t     reg_id;     // decoded register

	// synchroniser and filter carrier
	pin_sync_if pins ();

	assign pins.raw = gpio_in_i;

	// synchronise and de-glitch every pin
	pin_filter u_pin_filter (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.pins   (pins.filter_mp)
	);

	// map an address onto one of the register pairs
	// the same decode serves reads and writes alike
	function automatic reg_id_t decode_reg(
		input logic [ADDR_WIDTH-1:0] addr
	);
		reg_id_t id;
		id = REG_NONE;
		if (addr == ADDR_STATE_LOW || addr == ADDR_STATE_HIGH) begin
			id = REG_STATE;
		end else if (addr == ADDR_OUT_LOW || addr == ADDR_OUT_HIGH) begin
			id = REG_OUT;
		end else if (addr == ADDR_INV_LOW || addr == ADDR_INV_HIGH) begin
			id = REG_INV;
		end else if (addr == ADDR_DIR_LOW || addr == ADDR_DIR_HIGH) begin
			id = REG_DIR;
		end else if (addr == ADDR_IER_LOW || addr == ADDR_IER_HIGH) begin
			id = REG_IER;
		end else if (addr == ADDR_TRI_LOW || addr == ADDR_TRI_HIGH) begin
			id = REG_TRI;
		end else if (addr == ADDR_ISR_LOW || addr == ADDR_ISR_HIGH) begin
			id = REG_ISR;
		end else if (addr == ADDR_RISE_LOW || addr == ADDR_RISE_HIGH)
		begin
			id = REG_RISE;
		end else if (addr == ADDR_FALL_LOW || addr == ADDR_FALL_HIGH)
		begin
			id = REG_FALL;
		end else if (addr == ADDR_FILT_LOW || addr == ADDR_FILT_HIGH)
		begin
			id = REG_FILT;
		end
		return id;
	endfunction : decode_reg

	// pin mask of the bank an address selects
	// used as the clear mask of a state read
	function automatic logic [15:0] bank_of(
		input logic [ADDR_WIDTH-1:0] addr
	);
		// odd addresses hold pins 15..8, even ones pins 7..0
		if (addr[BANK_BIT]) begin
			return 16'hFF00;
		end else begin
			return 16'h00FF;
		end
	endfunction : bank_of

	// write one byte into its bank of a 16-bit register
	// the other bank keeps its value, banks are independent
	function automatic logic [15:0] merge_byte(
		input logic [15:0]           old,
		input logic [BANK_WIDTH-1:0] data,
		input logic [ADDR_WIDTH-1:0] addr
	);
		if (addr[BANK_BIT]) begin
			return {data, old[7:0]};
		end else begin
			return {old[15:8], data};
		end
	endfunction : merge_byte

	// pick the addressed byte out of a 16-bit register
	// reads never disturb the register they look at
	function automatic logic [7:0] pick_byte(
		input logic [15:0]           word,
		input logic [ADDR_WIDTH-1:0] addr
	);
		if (addr[BANK_BIT]) begin
			return word[15:8];
		end else begin
			return word[7:0];
		end
	endfunction : pick_byte

	// all next-state logic of the core
	always_comb begin
		next_st   = st;
		reg_id    = decode_reg(reg_addr_i);
		bank_mask = bank_of(reg_addr_i);

		// edges compare against last cycle's qualified level, so a
		// filter switch with differing levels shows as one edge
		// filtered pins use the held level, others the raw sample
		level = (st.filt_en & pins.filt)
			| (~st.filt_en & pins.sync);
		rise  = level & ~st.level_d;
		fall  = ~level & st.level_d;

		// only enabled inputs may ever flag an interrupt
		// dropping flags of disarmed pins keeps stale events from
		// surfacing when the pin is enabled again
		armed    = st.dir & st.irq_en;
		any_mode = ~st.rise_sel & ~st.fall_sel;

		// edge qualification per mode; any-edge counts a move away
		// from the captured level, a move back is a revert
		set_irq = armed & (
			(any_mode & (rise | fall) & (level ^ st.captured))
			| (st.rise_sel & rise)
			| (st.fall_sel & fall));

		// revert clearing exists only in any-edge mode
		revert_clr = any_mode & ~(level ^ st.captured);

		// a state read clears its own bank
		// the other bank keeps its flags untouched
		if (reg_rd_i && reg_id == REG_STATE) begin
			read_clr = bank_mask;
		end else begin
			read_clr = 16'h0000;
		end

		// a new event wins over any clear in the same cycle
		next_st.status = armed & (set_irq
			| (st.status & ~read_clr & ~revert_clr));
		next_st.level_d = level;

		// state read snapshots levels for revert clearing
		next_st.captured = (st.captured & ~read_clr)
			| (level & read_clr);

		// readback: inputs show sensed level, outputs written level
		// inputs read the synchronised raw level, not the filtered
		// one, so a read shows the pin as it is now
		state_view = (st.dir & (pins.sync ^ st.invert))
			| (~st.dir & st.out_level);

		// register writes; state and status pairs take none
		if (reg_wr_i) begin
			if (reg_id == REG_OUT) begin
				next_st.out_level = merge_byte(st.out_level,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_INV) begin
				next_st.invert = merge_byte(st.invert,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_DIR) begin
				next_st.dir = merge_byte(st.dir,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_IER) begin
				next_st.irq_en = merge_byte(st.irq_en,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_TRI) begin
				next_st.tri_en = merge_byte(st.tri_en,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_RISE) begin
				next_st.rise_sel = merge_byte(st.rise_sel,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_FALL) begin
				next_st.fall_sel = merge_byte(st.fall_sel,
					reg_wdata_i, reg_addr_i);
			end else if (reg_id == REG_FILT) begin
				next_st.filt_en = merge_byte(st.filt_en,
					reg_wdata_i, reg_addr_i);
			end
			// state, status and unmapped writes fall through
		end

		// read data, one cycle after the request
		// zero between answers so stale data is easy to spot
		next_st.rvalid = reg_rd_i;
		if (!reg_rd_i) begin
			next_st.rdata = 8'h00;
		end else if (reg_id == REG_STATE) begin
			next_st.rdata = pick_byte(state_view, reg_addr_i);
		end else if (reg_id == REG_OUT) begin
			next_st.rdata = pick_byte(st.out_level, reg_addr_i);
		end else if (reg_id == REG_INV) begin
			next_st.rdata = pick_byte(st.invert, reg_addr_i);
		end else if (reg_id == REG_DIR) begin
			next_st.rdata = pick_byte(st.dir, reg_addr_i);
		end else if (reg_id == REG_IER) begin
			next_st.rdata = pick_byte(st.irq_en, reg_addr_i);
		end else if (reg_id == REG_TRI) begin
			next_st.rdata = pick_byte(st.tri_en, reg_addr_i);
		end else if (reg_id == REG_ISR) begin
			next_st.rdata = pick_byte(st.status, reg_addr_i);
		end else if (reg_id == REG_RISE) begin
			next_st.rdata = pick_byte(st.rise_sel, reg_addr_i);
		end else if (reg_id == REG_FALL) begin
			next_st.rdata = pick_byte(st.fall_sel, reg_addr_i);
		end else if (reg_id == REG_FILT) begin
			next_st.rdata = pick_byte(st.filt_en, reg_addr_i);
		end else begin
			// unmapped addresses read as zero
			next_st.rdata = 8'h00;
		end

		// drive only outputs that are not three-stated
		// taken from the next values so the pins follow a write
		// on the same edge as the register itself
		next_st.oe = ~next_st.dir & ~next_st.tri_en;

		// interrupt pin follows the pending flags
		// also from the next flags, so the pin and the status bits
		// never disagree for a cycle
		next_st.irq_n = ~|next_st.status;
	end

	// state register
	// synchronous reset puts every field back to power-up values
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= CORE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign reg_rdata_o  = st.rdata;
	assign reg_rvalid_o = st.rvalid;
	assign gpio_out_o   = st.out_level;
	assign gpio_oe_o    = st.oe;
	assign irq_n_o      = st.irq_n;
endmodule : gpio_expander_pin_interrupt_core

// ==== rtl/gpio_pkg.sv ====
// shared constants and types for the 16-pin expander core
package gpio_pkg;
	// pin and bank geometry
	localparam int PIN_COUNT  = 16;
	localparam int BANK_WIDTH = 8;
	localparam int ADDR_WIDTH = 8;
	localparam int CNT_WIDTH  = 8;
	// bank select bit within the register address
	localparam int BANK_BIT   = 0;

	// register addresses, low bank even, high bank odd
	localparam logic [7:0] ADDR_STATE_LOW  = 8'h00;
	localparam logic [7:0] ADDR_STATE_HIGH = 8'h01;
	localparam logic [7:0] ADDR_OUT_LOW    = 8'h02;
	localparam logic [7:0] ADDR_OUT_HIGH   = 8'h03;
	localparam logic [7:0] ADDR_INV_LOW    = 8'h04;
	localparam logic [7:0] ADDR_INV_HIGH   = 8'h05;
	localparam logic [7:0] ADDR_DIR_LOW    = 8'h06;
	localparam logic [7:0] ADDR_DIR_HIGH   = 8'h07;
	localparam logic [7:0] ADDR_IER_LOW    = 8'h0A;
	localparam logic [7:0] ADDR_IER_HIGH   = 8'h0B;
	localparam logic [7:0] ADDR_TRI_LOW    = 8'h0C;
	localparam logic [7:0] ADDR_TRI_HIGH   = 8'h0D;
	localparam logic [7:0] ADDR_ISR_LOW    = 8'h0E;
	localparam logic [7:0] ADDR_ISR_HIGH   = 8'h0F;
	localparam logic [7:0] ADDR_RISE_LOW   = 8'h10;
	localparam logic [7:0] ADDR_RISE_HIGH  = 8'h11;
	localparam logic [7:0] ADDR_FALL_LOW   = 8'h12;
	localparam logic [7:0] ADDR_FALL_HIGH  = 8'h13;
	localparam logic [7:0] ADDR_FILT_LOW   = 8'h14;
	localparam logic [7:0] ADDR_FILT_HIGH  = 8'h15;

	// reset values, both banks together
	localparam logic [15:0] OUT_LEVEL_RESET = 16'hFFFF;
	localparam logic [15:0] INVERT_RESET    = 16'h0000;
	localparam logic [15:0] DIR_RESET       = 16'hFFFF;
	localparam logic [15:0] IRQ_EN_RESET    = 16'h0000;
	localparam logic [15:0] TRI_RESET       = 16'h0000;
	localparam logic [15:0] RISE_RESET      = 16'h0000;
	localparam logic [15:0] FALL_RESET      = 16'h0000;
	localparam logic [15:0] FILT_EN_RESET   = 16'hFFFF;

	// glitch filter timing: a level must hold more than this long
	localparam int CLK_PERIOD_PS = 5000;
	localparam int FILTER_NS     = 1075;
	localparam logic [7:0] FILTER_CYCLES =
		8'((FILTER_NS * 1000) / CLK_PERIOD_PS + 1);

	// register selector produced by the address decoder
	typedef enum logic [3:0] {
		REG_NONE, REG_STATE, REG_OUT, REG_INV, REG_DIR,
		REG_IER, REG_TRI, REG_ISR, REG_RISE, REG_FALL, REG_FILT
	} reg_id_t;
endpackage : gpio_pkg

// ==== rtl/pin_filter.sv ====
// two-flop synchroniser and per-pin stability filter
`timescale 1ns/1ps
module pin_filter
	import gpio_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  srst_i,
	pin_sync_if.filter_mp pins
);
	// complete state of the filter
	typedef struct packed {
		logic [15:0]                 sync1; // first sampling stage
		logic [15:0]                 sync2; // second sampling stage
		logic [15:0]                 filt;  // accepted stable level
		logic [15:0][CNT_WIDTH-1:0]  cnt;   // cycles of disagreement
	} filter_state_t;

	filter_state_t st;      // registered state
	filter_state_t next_st; // next state

	// next-state logic for every pin
	always_comb begin
		next_st       = st;
		next_st.sync1 = pins.raw;
		next_st.sync2 = st.sync1;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (st.sync2[i] == st.filt[i]) begin
				// level agrees, restart the hold count
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] == FILTER_CYCLES - 8'h01) begin
				// new level held long enough, accept it
				next_st.filt[i] = st.sync2[i];
				next_st.cnt[i]  = '0;
			end else begin
				// still counting; short pulses die here
				next_st.cnt[i] = st.cnt[i] + 8'h01;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pins.sync = st.sync2;
	assign pins.filt = st.filt;
endmodule : pin_filter

// ==== rtl/pin_sync_if.sv ====
// carrier between the core and its pin synchroniser / filter
`timescale 1ns/1ps
interface pin_sync_if;
	logic [15:0] raw;  // pin levels as they arrive
	logic [15:0] sync; // two-flop synchronised levels
	logic [15:0] filt; // glitch-filtered levels

	// filter side receives raw pins and returns cleaned levels
	modport filter_mp (input raw, output sync, output filt);
	// core side feeds pins and consumes the results
	modport core_mp (output raw, input sync, input filt);
endinterface : pin_sync_if

// ==== tb/gpio_core_chk.sv ====
// port assertions for the expander core
`timescale 1ns/1ps
module gpio_core_chk
	import gpio_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	input  wire logic [ADDR_WIDTH-1:0] reg_addr_i,
	input  wire logic [BANK_WIDTH-1:0] reg_wdata_i,
	input  wire logic [BANK_WIDTH-1:0] reg_rdata_o,
	input  wire logic                  reg_rvalid_o,
	input  wire logic [PIN_COUNT-1:0]  gpio_in_i,
	input  wire logic [PIN_COUNT-1:0]  gpio_out_o,
	input  wire logic [PIN_COUNT-1:0]  gpio_oe_o,
	input  wire logic                  irq_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// read strobe then valid answer
	sequence s_read;
		reg_rd_i ##1 reg_rvalid_o;
	endsequence
	// all pins driven for several cycles
	sequence s_all_out;
		(gpio_oe_o == 16'hFFFF)[*4];
	endsequence
	a_read_answer: assert property (reg_rd_i |-> s_read)
		else $error("read not answered after one cycle");
	a_no_stray: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("read valid without a read");
	a_idle_rdata: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
		else $error("read data not zero while idle");
	a_out_write: assert property ((reg_wr_i && reg_addr_i == ADDR_OUT_LOW)
		|=> gpio_out_o[7:0] == $past(reg_wdata_i))
		else $error("output level not taken from write");
	a_dir_input: assert property ((reg_wr_i && reg_addr_i == ADDR_DIR_HIGH
		&& reg_wdata_i[7]) |=> !gpio_oe_o[15])
		else $error("input pin still driven");
	a_state_wr_void: assert property ((reg_wr_i && reg_addr_i ==
		ADDR_STATE_LOW) |=> $stable(gpio_out_o) && $stable(gpio_oe_o))
		else $error("state write changed the pins");
	a_out_no_irq: assert property (s_all_out |-> irq_n_o)
		else $error("interrupt with all pins outputs");
	a_reset_state: assert property ($fell(srst_i) |-> gpio_out_o ==
		OUT_LEVEL_RESET && gpio_oe_o == 16'h0000 && irq_n_o)
		else $error("pins not at reset state");
endmodule : gpio_core_chk

bind gpio_expander_pin_interrupt_core gpio_core_chk u_chk (
	.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .gpio_in_i(gpio_in_i),
	.gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o), .irq_n_o(irq_n_o)
);

// ==== tb/gpio_expander_pin_interrupt_core_bench.sv ====
// self-checking bench for the expander core
`timescale 1ns/1ps
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module gpio_expander_pin_interrupt_core_bench
	import gpio_pkg::*;
;
	logic        clk;      // system clock
	logic        srst;     // sync reset
	logic        wr;       // write strobe
	logic        rd;       // read strobe
	logic        rvalid;   // read valid
	logic        irq_n;    // interrupt, low
	logic [7:0]  addr;     // register address
	logic [7:0]  wdata;    // write data
	logic [7:0]  rdata;    // read data
	logic [7:0]  d;        // last read value
	logic [7:0]  e;        // expected byte
	logic [15:0] gpio_in;  // pin levels
	logic [15:0] gpio_out; // output levels
	logic [15:0] gpio_oe;  // drive enables
	logic [7:0]  mdl [0:21];            // register model
	logic [31:0] seed = 32'h0001_255D;  // random state
	int          pend;                  // modelled pending, pin 0
	int          cap;                   // modelled captured level
	int          n_fail = 0;
	int          samples_checked = 0;

	// clock generator
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	gpio_expander_pin_interrupt_core u_gpio_expander_pin_interrupt_core (
		.clk_i(clk), .srst_i(srst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .gpio_in_i(gpio_in),
		.gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe), .irq_n_o(irq_n)
	);
	reg_host host (
		.clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid)
	);

	// next pseudo-random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// reset pulse and model back to defaults
	task automatic do_reset;
		@(negedge clk);
		srst    = 1'b1;
		gpio_in = 16'h0000;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		for (int a = 0; a < 22; a++) mdl[a] = 8'h00;
		for (int b = 0; b < 2; b++) begin
			mdl[2+b]  = OUT_LEVEL_RESET[8*b +: 8];
			mdl[6+b]  = DIR_RESET[8*b +: 8];
			mdl[20+b] = FILT_EN_RESET[8*b +: 8];
		end
		pend = 0;
		cap  = 0;
	endtask : do_reset
	// write, model keeps only writable places
	task automatic mdl_wr(input logic [7:0] a, input logic [7:0] v);
		host.wr_reg(a, v);
		if (a inside {[2:7], [10:13], [16:21]}) mdl[a] = v;
	endtask : mdl_wr
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] x);
		host.rd_reg(a, d);
		`CHK(d, x)
	endtask : chk_rd
	// read back every register but state and status
	task automatic check_all;
		for (int a = 2; a < 22; a++)
			if (!(a inside {14, 15})) chk_rd(8'(a), mdl[a]);
	endtask : check_all
	// move pin 0, model pending by mode, check interrupt
	task automatic edge_to(input logic v, input int m, input int w);
		@(negedge clk);
		gpio_in[0] = v;
		if (m == 0) pend = (v != cap);
		else if ((v && m[1]) || (!v && m[0])) pend = 1;
		repeat (w) @(negedge clk);
		`CHK(irq_n, pend == 0)
		chk_rd(ADDR_ISR_LOW, 8'(pend));
	endtask : edge_to
	// state read clears pending and captures level
	task automatic clear_rd;
		host.rd_reg(ADDR_STATE_LOW, d);
		pend = 0;
		cap  = gpio_in[0];
		repeat (3) @(negedge clk);
		`CHK(irq_n, 1'b1)
	endtask : clear_rd

	// main sequence
	initial begin
		srst    = 1'b1;
		gpio_in = 16'h0000;
		do_reset();
		check_all();
		for (int a = 0; a < 22; a++) begin
			seed = lfsr(seed);
			if (!(a inside {14, 15})) mdl_wr(8'(a), seed[7:0]);
		end
		check_all();
		`CHK(gpio_out, {mdl[3], mdl[2]})
		`CHK(gpio_oe, ~{mdl[7], mdl[6]} & ~{mdl[13], mdl[12]})
		$display("test registers done");
		repeat (4) begin
			seed = lfsr(seed);
			mdl_wr(ADDR_INV_LOW, seed[15:8]);
			gpio_in = seed[31:16];
			repeat (4) @(negedge clk);
			for (int b = 0; b < 2; b++) begin
				e = ((gpio_in[8*b +: 8] ^ mdl[4+b]) & mdl[6+b])
					| (mdl[2+b] & ~mdl[6+b]);
				chk_rd(8'(b), e);
			end
		end
		$display("test pin state done");
		do_reset();
		mdl_wr(ADDR_FILT_LOW, 8'h00);
		mdl_wr(ADDR_IER_LOW, 8'h01);
		for (int m = 0; m < 4; m++) begin
			mdl_wr(ADDR_RISE_LOW, {7'h00, m[1]});
			mdl_wr(ADDR_FALL_LOW, {7'h00, m[0]});
			clear_rd();
			edge_to(1'b1, m, 6);
			edge_to(1'b0, m, 6);
			clear_rd();
		end
		mdl_wr(ADDR_IER_LOW, 8'h00);
		edge_to(1'b1, 4, 6);
		mdl_wr(ADDR_IER_LOW, 8'h01);
		mdl_wr(ADDR_DIR_LOW, 8'h00);
		mdl_wr(ADDR_DIR_HIGH, 8'h00);
		edge_to(1'b0, 4, 6);
		mdl_wr(ADDR_DIR_HIGH, 8'hFF);
		$display("test edge modes done");
		do_reset();
		mdl_wr(ADDR_IER_LOW, 8'h01);
		for (int i = 0; i < 3; i++) begin
			mdl_wr(ADDR_RISE_LOW, {7'h00, i == 0});
			mdl_wr(ADDR_FALL_LOW, {7'h00, i == 1});
			clear_rd();
			gpio_in[0] = (i != 1);
			repeat (40) @(negedge clk);
			gpio_in[0] = (i == 1);
			repeat (250) @(negedge clk);
			`CHK(irq_n, 1'b1)
			gpio_in[0] = (i != 1);
			repeat (200) @(negedge clk);
			`CHK(irq_n, 1'b1)
			repeat (40) @(negedge clk);
			`CHK(irq_n, 1'b0)
		end
		clear_rd();
		$display("test glitch filter done");
		report_and_stop();
	end

	// hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule : gpio_expander_pin_interrupt_core_bench

// ==== tb/reg_host.sv ====
// register host model driving the core's strobe port
`timescale 1ns/1ps
module reg_host
	import gpio_pkg::*;
(
	input  wire logic                  clk_i,
	output logic                       reg_wr_o,
	output logic                       reg_rd_o,
	output logic      [ADDR_WIDTH-1:0] reg_addr_o,
	output logic      [BANK_WIDTH-1:0] reg_wdata_o,
	input  wire logic [BANK_WIDTH-1:0] reg_rdata_i,
	input  wire logic                  reg_rvalid_i
);
	// idle values at time zero
	initial begin
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_addr_o  = 8'h3C;
		reg_wdata_o = 8'hA5;
	end
	// idle lines flip so stale values never pass
	task automatic park;
		reg_addr_o  = ~reg_addr_o;
		reg_wdata_o = ~reg_wdata_o;
	endtask : park
	// one write strobe, command value keeps bit 7 clear
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_i);
		reg_wr_o    = 1'b1;
		reg_addr_o  = a;
		reg_wdata_o = v;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		park();
	endtask : wr_reg
	// one read strobe, data taken while valid stands
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk_i);
		reg_rd_o   = 1'b1;
		reg_addr_o = a;
		@(negedge clk_i);
		reg_rd_o = 1'b0;
		park();
		v = reg_rvalid_i ? reg_rdata_i : 8'hxx;
	endtask : rd_reg
endmodule : reg_host
